// *** rtl/wbm_pkg.sv ***
package wbm_pkg;
    localparam int CLK_PS = 8000;
    localparam int IFC48_PS = 20800;
    localparam int IFC30_PS = 33334;
    localparam int DIV48 = (IFC48_PS + CLK_PS - 1) / CLK_PS;
    localparam int DIV30 = (IFC30_PS + CLK_PS - 1) / CLK_PS;
    localparam int VEC_N = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h01;
    localparam logic [7:0] OFS_TC0 = 8'h02;
    localparam logic [7:0] OFS_TC3 = 8'h05;
    localparam logic [7:0] OFS_ADRL = 8'h06;
    localparam logic [7:0] OFS_ADRH = 8'h07;
    localparam logic [7:0] OFS_VIDX = 8'h08;
    localparam logic [7:0] OFS_VB0 = 8'h09;
    localparam logic [7:0] OFS_VB2 = 8'h0b;
    localparam logic [7:0] OFS_CRST = 8'h0c;
    localparam logic [7:0] OFS_E1B0 = 8'h0d;
    localparam logic [7:0] OFS_E2B2 = 8'h12;
    localparam logic [7:0] OFS_IDLE = 8'h13;
    localparam int CTRL_GO = 0;
    localparam int CTRL_W16 = 1;
    localparam int CTRL_FSEL = 2;
    localparam int CTRL_CSEL = 4;
    localparam int CTRL_CMODE = 6;
    localparam int STAT_DONE = 1;
    localparam logic [1:0] CSEL_48 = 2'h0;
    localparam logic [1:0] CSEL_30 = 2'h1;
    localparam logic [2:0] RDY_ALWAYS = 3'h6;
    localparam logic [9:0] ECC_BLK256 = 10'h0ff;
    localparam logic [9:0] ECC_BLK512 = 10'h1ff;
    typedef logic [7:0] wbm_byte_t;
    typedef logic [15:0] wbm_word_t;
    typedef struct packed {
        logic [6:0] spare;
        logic [2:0] branch;
        logic last;
        logic data_oe;
        logic addr_inc;
        logic fifo_adv;
        logic rdy_pol;
        logic [2:0] rdy_sel;
        logic [5:0] ctl;
    } wbm_vec_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } wbm_state_t;
endpackage

// *** rtl/wbm_top.sv ***
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module wbm_top (
    // Clock, reset, enable
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    // Register port
    input wire wbm_pkg::wbm_byte_t REG_ADDR_I,
    input wire wbm_pkg::wbm_byte_t REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output wbm_pkg::wbm_byte_t REG_RDATA_O,
    // Waveform pins
    output logic [5:0] WAVE_CONTROL_O,
    output logic [8:0] WAVE_ADDRESS_O,
    input wire logic [5:0] WAVE_READY_I,
    input wire logic INTERFACE_CLOCK_I,
    input wire wbm_pkg::wbm_word_t DATA_I,
    output wbm_pkg::wbm_word_t DATA_O,
    output logic DATA_OE_O,
    // Endpoint FIFO side
    output logic [1:0] FIFO_SELECT_O,
    input wire wbm_pkg::wbm_word_t FIFO_RDATA_I,
    input wire logic FIFO_EMPTY_I,
    input wire logic FIFO_FULL_I,
    output logic FIFO_ADV_O,
    output wbm_pkg::wbm_word_t FIFO_WDATA_O,
    // Slave port byte traffic
    input wire wbm_pkg::wbm_byte_t SLV_BYTE_I,
    input wire logic SLV_VALID_I
);
    import wbm_pkg::*;

    function automatic logic rdy_ok(wbm_vec_t v, logic [5:0] r);
        if (v.rdy_sel >= RDY_ALWAYS) begin
            return 1'b1;
        end
        return r[v.rdy_sel] == v.rdy_pol;
    endfunction

    function automatic logic [23:0] ecc_code(logic [7:0] c,
            logic [8:0] lo, logic [8:0] le, logic m512);
        logic [5:0] cp;
        logic [17:0] lp;
        cp = {^(c & 8'hf0), ^(c & 8'h0f), ^(c & 8'hcc),
              ^(c & 8'h33), ^(c & 8'haa), ^(c & 8'h55)};
        for (int k = 0; k < 9; k++) begin
            lp[2*k] = le[k];
            lp[2*k+1] = lo[k];
        end
        if (m512) begin
            return {cp, lp};
        end
        return {cp, 2'h3, lp[15:0]};
    endfunction

    // Input synchronisers
    logic [5:0] rdy_s1_r, rdy_s2_r;
    wbm_word_t din_s1_r, din_s2_r;
    logic ifc_s1_r, ifc_s2_r, ifc_s3_r;

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            rdy_s1_r <= 6'h00;
            rdy_s2_r <= 6'h00;
            din_s1_r <= 16'h0000;
            din_s2_r <= 16'h0000;
            ifc_s1_r <= 1'b0;
            ifc_s2_r <= 1'b0;
            ifc_s3_r <= 1'b0;
        end else if (CE_I) begin
            rdy_s1_r <= WAVE_READY_I;
            rdy_s2_r <= rdy_s1_r;
            din_s1_r <= DATA_I;
            din_s2_r <= din_s1_r;
            ifc_s1_r <= INTERFACE_CLOCK_I;
            ifc_s2_r <= ifc_s1_r;
            ifc_s3_r <= ifc_s2_r;
        end
    end

    // Configuration
    logic w16_r, cmode_r;
    logic [1:0] fsel_r, csel_r;
    logic [5:0] idle_ctl_r;
    logic [2:0] vidx_r;
    logic wr_ctrl;
    assign wr_ctrl = REG_WR_I && REG_ADDR_I == OFS_CTRL;

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            w16_r <= 1'b0;
            cmode_r <= 1'b0;
            fsel_r <= 2'h0;
            csel_r <= CSEL_48;
            idle_ctl_r <= 6'h00;
            vidx_r <= 3'h0;
        end else if (CE_I && REG_WR_I) begin
            if (REG_ADDR_I == OFS_CTRL) begin
                w16_r <= REG_WDATA_I[CTRL_W16];
                fsel_r <= REG_WDATA_I[CTRL_FSEL +: 2];
                csel_r <= REG_WDATA_I[CTRL_CSEL +: 2];
                cmode_r <= REG_WDATA_I[CTRL_CMODE];
            end
            if (REG_ADDR_I == OFS_IDLE) begin
                idle_ctl_r <= REG_WDATA_I[5:0];
            end
            if (REG_ADDR_I == OFS_VIDX) begin
                vidx_r <= REG_WDATA_I[2:0];
            end
        end
    end

    // State vector memory
    logic [23:0] vmem [VEC_N];

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            for (int i = 0; i < VEC_N; i++) begin
                vmem[i] <= 24'h000000;
            end
        end else if (CE_I && REG_WR_I) begin
            for (int b = 0; b < 3; b++) begin
                if (REG_ADDR_I == OFS_VB0 + 8'(b)) begin
                    vmem[vidx_r][8*b +: 8] <= REG_WDATA_I;
                end
            end
        end
    end

    // Interface tick
    logic [2:0] div_r, div_lim;
    logic tick;
    assign div_lim = (csel_r == CSEL_30) ? 3'(DIV30 - 1) : 3'(DIV48 - 1);
    assign tick = csel_r[1] ? (ifc_s2_r & ~ifc_s3_r)
                            : (div_r == div_lim);

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            div_r <= 3'h0;
        end else if (CE_I) begin
            div_r <= (div_r >= div_lim) ? 3'h0 : div_r + 3'h1;
        end
    end

    // Engine sequencing
    wbm_state_t st_r, st_nxt;
    logic [2:0] pc_r, pc_nxt;
    logic [31:0] tc_r;
    wbm_vec_t v, vn;
    logic cond, stall, step, go, fin, start_ok, start_zero;
    assign v = wbm_vec_t'(vmem[pc_r]);
    assign vn = wbm_vec_t'(vmem[pc_nxt]);
    assign cond = rdy_ok(v, rdy_s2_r);
    assign stall = v.fifo_adv & (v.data_oe ? FIFO_EMPTY_I : FIFO_FULL_I);
    assign step = CE_I & tick & (st_r == ST_RUN);
    assign go = step & ~stall & cond;
    assign fin = go & v.last & (tc_r == 32'h1);
    assign start_ok = wr_ctrl & REG_WDATA_I[CTRL_GO] & (tc_r != 32'h0)
                      & (st_r == ST_IDLE);
    assign start_zero = wr_ctrl & REG_WDATA_I[CTRL_GO]
                        & (tc_r == 32'h0) & (st_r == ST_IDLE);

    always_comb begin
        st_nxt = st_r;
        pc_nxt = pc_r;
        case (st_r)
            ST_IDLE: begin
                if (start_ok) begin
                    st_nxt = ST_RUN;
                    pc_nxt = 3'h0;
                end
            end
            ST_RUN: begin
                if (step && !stall) begin
                    if (!cond) begin
                        pc_nxt = v.branch;
                    end else if (v.last) begin
                        pc_nxt = 3'h0;
                        if (tc_r == 32'h1) begin
                            st_nxt = ST_IDLE;
                        end
                    end else begin
                        pc_nxt = pc_r + 3'h1;
                    end
                end
            end
            default: begin
                st_nxt = ST_IDLE;
                pc_nxt = 3'h0;
            end
        endcase
    end

    logic done_r, stall_r;

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            st_r <= ST_IDLE;
            pc_r <= 3'h0;
            done_r <= 1'b0;
            stall_r <= 1'b0;
        end else if (CE_I) begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            stall_r <= (st_r == ST_RUN) & stall;
            if (fin || start_zero) begin
                done_r <= 1'b1;
            end else if (start_ok || (REG_WR_I
                    && REG_ADDR_I == OFS_STAT
                    && REG_WDATA_I[STAT_DONE])) begin
                done_r <= 1'b0;
            end
        end
    end

    // Transaction count
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            tc_r <= 32'h0;
        end else if (CE_I) begin
            if (go && v.last) begin
                tc_r <= tc_r - 32'h1;
            end else if (REG_WR_I && st_r == ST_IDLE
                    && REG_ADDR_I >= OFS_TC0
                    && REG_ADDR_I <= OFS_TC3) begin
                tc_r[8*2'(REG_ADDR_I[1:0] - 2'h2) +: 8] <= REG_WDATA_I;
            end
        end
    end

    // Pin outputs
    logic [5:0] ctl_r;
    logic [8:0] addr_r;
    logic oe_r;
    wbm_word_t dout_r;

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ctl_r <= 6'h00;
            oe_r <= 1'b0;
            dout_r <= 16'h0000;
        end else if (CE_I) begin
            ctl_r <= (st_nxt == ST_RUN) ? vn.ctl : idle_ctl_r;
            oe_r <= (st_nxt == ST_RUN) & vn.data_oe;
            if (go && v.fifo_adv && v.data_oe) begin
                dout_r <= w16_r ? FIFO_RDATA_I
                                : {8'h00, FIFO_RDATA_I[7:0]};
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            addr_r <= 9'h000;
        end else if (CE_I) begin
            if (go && v.addr_inc) begin
                addr_r <= addr_r + 9'h001;
            end else if (REG_WR_I && REG_ADDR_I == OFS_ADRL) begin
                addr_r[7:0] <= REG_WDATA_I;
            end else if (REG_WR_I && REG_ADDR_I == OFS_ADRH) begin
                addr_r[8] <= REG_WDATA_I[0];
            end
        end
    end

    assign WAVE_CONTROL_O = ctl_r;
    assign WAVE_ADDRESS_O = addr_r;
    assign DATA_O = dout_r;
    assign DATA_OE_O = oe_r;
    assign FIFO_SELECT_O = fsel_r;
    assign FIFO_ADV_O = go & v.fifo_adv;
    assign FIFO_WDATA_O = w16_r ? din_s2_r : {8'h00, din_s2_r[7:0]};

    a_stall_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        step && stall |=> $stable(pc_r) && $stable(tc_r))
        else $error("engine moved during FIFO stall");
    a_tc_count: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        go && v.last |=> tc_r == $past(tc_r) - 32'h1)
        else $error("transaction count not decremented");
    a_done_idle: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        fin |=> st_r == ST_IDLE && done_r && tc_r == 32'h0)
        else $error("completion did not idle engine");
    a_addr_step: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        go && v.addr_inc |=> addr_r == $past(addr_r) + 9'h001)
        else $error("address did not advance");
    a_branch_take: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        step && !stall && !cond |=> pc_r == $past(v.branch))
        else $error("ready branch not taken");
    a_ctl_tick: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        st_r == ST_RUN && $past(st_r) == ST_RUN && !$past(step)
        |-> $stable(ctl_r))
        else $error("control changed without tick");
    a_width8_out: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        !w16_r && $past(go && v.fifo_adv && v.data_oe) |->
        DATA_O[15:8] == 8'h00)
        else $error("upper byte driven in 8-bit mode");

    // Error-correcting code generator
    wbm_byte_t eb;
    logic ev, p;
    logic [7:0] col_r, col_n;
    logic [8:0] lpo_r, lpe_r, lpo_n, lpe_n, idx;
    logic [9:0] cnt_r;
    logic full_r, crst;
    logic [23:0] code_result_first_r, code_result_second_r, code_n;
    assign crst = REG_WR_I && REG_ADDR_I == OFS_CRST;
    assign eb = (st_r == ST_RUN)
        ? (v.data_oe ? FIFO_RDATA_I[7:0] : din_s2_r[7:0]) : SLV_BYTE_I;
    assign ev = ~w16_r & ((st_r == ST_RUN) ? (go & v.fifo_adv)
                                           : SLV_VALID_I);
    assign p = ^eb;
    assign idx = cmode_r ? cnt_r[8:0] : {1'b0, cnt_r[7:0]};
    assign col_n = col_r ^ eb;
    assign lpo_n = lpo_r ^ ({9{p}} & idx);
    assign lpe_n = lpe_r ^ ({9{p}} & ~idx);
    assign code_n = ecc_code(col_n, lpo_n, lpe_n, cmode_r);

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            col_r <= 8'h00;
            lpo_r <= 9'h000;
            lpe_r <= 9'h000;
            cnt_r <= 10'h000;
            full_r <= 1'b0;
            code_result_first_r <= 24'h000000;
            code_result_second_r <= 24'h000000;
        end else if (CE_I) begin
            if (crst) begin
                col_r <= 8'h00;
                lpo_r <= 9'h000;
                lpe_r <= 9'h000;
                cnt_r <= 10'h000;
                full_r <= 1'b0;
            end else if (ev && !full_r) begin
                cnt_r <= cnt_r + 10'h001;
                col_r <= col_n;
                lpo_r <= lpo_n;
                lpe_r <= lpe_n;
                if (!cmode_r && cnt_r == ECC_BLK256) begin
                    code_result_first_r <= code_n;
                    col_r <= 8'h00;
                    lpo_r <= 9'h000;
                    lpe_r <= 9'h000;
                end
                if (cnt_r == ECC_BLK512) begin
                    full_r <= 1'b1;
                    if (cmode_r) begin
                        code_result_first_r <= code_n;
                    end else begin
                        code_result_second_r <= code_n;
                    end
                end
            end
        end
    end

    a_code_freeze: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        full_r && !crst |=> $stable(code_result_first_r) && $stable(code_result_second_r))
        else $error("code result changed after completion");
    a_wide_ignore: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        w16_r && !crst |=> $stable(cnt_r) && $stable(col_r))
        else $error("code accumulated 16-bit traffic");
    a_single_code: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmode_r && !crst |=> $stable(code_result_second_r))
        else $error("second result touched in single mode");

    // Register readback
    wbm_byte_t rd_mux, rdata_r;
    logic [4:0] eo;
    logic [47:0] ecc_all;
    assign eo = 5'(REG_ADDR_I - OFS_E1B0);
    assign ecc_all = {code_result_second_r, code_result_first_r};

    always_comb begin
        rd_mux = 8'h00;
        if (REG_ADDR_I == OFS_CTRL) begin
            rd_mux = {1'b0, cmode_r, csel_r, fsel_r, w16_r, 1'b0};
        end else if (REG_ADDR_I == OFS_STAT) begin
            rd_mux = {5'h00, stall_r, done_r, st_r == ST_RUN};
        end else if (REG_ADDR_I >= OFS_TC0 && REG_ADDR_I <= OFS_TC3) begin
            rd_mux = tc_r[8*2'(REG_ADDR_I[1:0] - 2'h2) +: 8];
        end else if (REG_ADDR_I == OFS_ADRL) begin
            rd_mux = addr_r[7:0];
        end else if (REG_ADDR_I == OFS_ADRH) begin
            rd_mux = {7'h00, addr_r[8]};
        end else if (REG_ADDR_I == OFS_VIDX) begin
            rd_mux = {5'h00, vidx_r};
        end else if (REG_ADDR_I >= OFS_VB0 && REG_ADDR_I <= OFS_VB2) begin
            rd_mux = vmem[vidx_r][8*(REG_ADDR_I - OFS_VB0) +: 8];
        end else if (REG_ADDR_I >= OFS_E1B0 && REG_ADDR_I <= OFS_E2B2) begin
            rd_mux = ecc_all[8*eo +: 8];
        end else if (REG_ADDR_I == OFS_IDLE) begin
            rd_mux = {2'h0, idle_ctl_r};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            rdata_r <= 8'h00;
        end else if (CE_I) begin
            rdata_r <= REG_RD_I ? rd_mux : 8'h00;
        end
    end

    assign REG_RDATA_O = rdata_r;
endmodule

// *** test/wbm_far.sv ***
`timescale 1ns/1ns
module wbm_far (
    // Clock and bench commands
    input wire logic clk_i,
    input wire logic hold_rdy_i,
    input wire logic stall_i,
    // From the design
    input wire logic fifo_adv_i,
    input wire logic data_oe_i,
    input wire wbm_pkg::wbm_word_t data_o_i,
    // To the design, and the advance count back to the bench
    output logic [5:0] ready_o,
    output wbm_pkg::wbm_word_t data_i_o,
    output wbm_pkg::wbm_word_t fifo_rdata_o,
    output logic fifo_empty_o,
    output logic fifo_full_o,
    output int adv_count_o
);
    import wbm_pkg::*;
    logic [15:0] pat_r = 16'h5a3c;
    wbm_word_t head_r = 16'h0001;
    int cnt_r = 0;
    // Changes every cycle so a released bus never reads stale
    always @(posedge clk_i) begin
        pat_r <= {pat_r[14:0], pat_r[15] ^ pat_r[13]};
    end
    // Show-ahead head moves on each pop or push
    always @(posedge clk_i) begin
        if (fifo_adv_i === 1'b1) begin
            cnt_r <= cnt_r + 1;
            head_r <= head_r + 16'h0103;
        end
    end
    assign adv_count_o = cnt_r;
    assign fifo_rdata_o = head_r;
    assign fifo_empty_o = stall_i;
    assign fifo_full_o = stall_i;
    assign ready_o = {pat_r[5:1], ~hold_rdy_i};
    // Wire level: design drives when enabled, else the far device
    assign data_i_o = data_oe_i ? data_o_i : pat_r;
endmodule

// *** test/wbm_top_tb.sv ***
`timescale 1ns/1ns
module wbm_top_tb;
    import wbm_pkg::*;
    logic CLK_I = 1'b0;
    logic NRST_I = 1'b0;
    logic CE_I = 1'b1;
    wbm_byte_t REG_ADDR_I = 8'h00;
    wbm_byte_t REG_WDATA_I = 8'h00;
    logic REG_WR_I = 1'b0;
    logic REG_RD_I = 1'b0;
    wbm_byte_t REG_RDATA_O;
    logic [5:0] WAVE_CONTROL_O;
    logic [8:0] WAVE_ADDRESS_O;
    logic [5:0] WAVE_READY_I;
    logic INTERFACE_CLOCK_I = 1'b0;
    wbm_word_t DATA_I, DATA_O, FIFO_RDATA_I, FIFO_WDATA_O;
    logic DATA_OE_O, FIFO_EMPTY_I, FIFO_FULL_I, FIFO_ADV_O;
    logic [1:0] FIFO_SELECT_O;
    wbm_byte_t SLV_BYTE_I = 8'h00;
    logic SLV_VALID_I = 1'b0;
    logic hold_rdy = 1'b0;
    logic stall = 1'b0;
    logic lk_en = 1'b0;
    logic in_run = 1'b0;
    logic w16 = 1'b0;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int advs, adv_cnt;
    logic [5:0] seen_q[$];
    logic [5:0] prev_ctl;
    wbm_byte_t bbuf[1024];

    wbm_top dut (.CLK_I(CLK_I), .NRST_I(NRST_I), .CE_I(CE_I),
        .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
        .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
        .WAVE_CONTROL_O(WAVE_CONTROL_O), .WAVE_ADDRESS_O(WAVE_ADDRESS_O),
        .WAVE_READY_I(WAVE_READY_I), .INTERFACE_CLOCK_I(INTERFACE_CLOCK_I), .DATA_I(DATA_I),
        .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .FIFO_SELECT_O(FIFO_SELECT_O),
        .FIFO_RDATA_I(FIFO_RDATA_I), .FIFO_EMPTY_I(FIFO_EMPTY_I),
        .FIFO_FULL_I(FIFO_FULL_I), .FIFO_ADV_O(FIFO_ADV_O),
        .FIFO_WDATA_O(FIFO_WDATA_O), .SLV_BYTE_I(SLV_BYTE_I),
        .SLV_VALID_I(SLV_VALID_I));
    wbm_far far (.clk_i(CLK_I), .hold_rdy_i(hold_rdy), .stall_i(stall),
        .fifo_adv_i(FIFO_ADV_O), .data_oe_i(DATA_OE_O), .data_o_i(DATA_O),
        .ready_o(WAVE_READY_I), .data_i_o(DATA_I), .fifo_rdata_o(FIFO_RDATA_I),
        .fifo_empty_o(FIFO_EMPTY_I), .fifo_full_o(FIFO_FULL_I),
        .adv_count_o(adv_cnt));

    always #4 CLK_I = ~CLK_I;
    // Link clock runs only during pin-clocked runs
    always begin
        #80;
        if (lk_en) INTERFACE_CLOCK_I = ~INTERFACE_CLOCK_I;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end
        else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] got);
        check_count++;
        if (got !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, e, got);
        end
    endtask

    // Control level changes during a run
    always @(negedge CLK_I) begin
        if (in_run && WAVE_CONTROL_O !== prev_ctl) begin
            seen_q.push_back(WAVE_CONTROL_O);
            prev_ctl = WAVE_CONTROL_O;
        end
        if (in_run && FIFO_ADV_O === 1'b1 && DATA_OE_O === 1'b0 && !w16)
            chk("push upper byte", 32'h0, 32'(FIFO_WDATA_O[15:8]));
    end

    task automatic wr(input wbm_byte_t a, input wbm_byte_t d);
        @(posedge CLK_I);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge CLK_I);
        REG_WR_I <= 1'b0;
    endtask

    task automatic rd(input wbm_byte_t a, output wbm_byte_t d);
        @(posedge CLK_I);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge CLK_I);
        REG_RD_I <= 1'b0;
        @(negedge CLK_I);
        d = REG_RDATA_O;
    endtask

    task automatic rdchk(input string w, input wbm_byte_t a,
                         input wbm_byte_t e);
        wbm_byte_t d;
        rd(a, d);
        chk(w, 32'(e), 32'(d));
    endtask

    task automatic rd24(input wbm_byte_t a, output logic [23:0] r);
        wbm_byte_t d0, d1, d2;
        rd(a, d0);
        rd(a + 8'h01, d1);
        rd(a + 8'h02, d2);
        r = {d2, d1, d0};
    endtask

    task automatic wvec(input wbm_byte_t i, input wbm_vec_t v);
        logic [23:0] b;
        b = v;
        wr(OFS_VIDX, i);
        wr(OFS_VB0, b[7:0]);
        wr(OFS_VB0 + 8'h01, b[15:8]);
        wr(OFS_VB2, b[23:16]);
    endtask

    task automatic send(input int s, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge CLK_I);
            SLV_VALID_I <= 1'b1;
            SLV_BYTE_I <= bbuf[s + i];
        end
        @(posedge CLK_I);
        SLV_VALID_I <= 1'b0;
    endtask

    function automatic logic [23:0] ecc(input int s, input int n);
        logic [17:0] lp;
        logic [5:0] cp;
        wbm_byte_t x;
        lp = '0;
        cp = '0;
        x = '0;
        for (int i = 0; i < n; i++) begin
            x ^= bbuf[s + i];
            for (int b = 0; b < 9; b++)
                lp[2 * b + ((i >> b) & 1)] ^= ^bbuf[s + i];
        end
        for (int i = 0; i < 8; i++)
            for (int b = 0; b < 3; b++)
                cp[2 * b + ((i >> b) & 1)] ^= x[i];
        return (n == 256) ? {cp, 2'b11, lp[15:0]} : {cp, lp};
    endfunction

    // Two-vector waveform: wait on ready, then move one unit
    task automatic run(input int cfg);
        wbm_vec_t v0, v1;
        logic [5:0] a, b, idl;
        logic [8:0] sa;
        logic [31:0] n;
        wbm_byte_t c, d;
        int k;
        logic [15:0] h;
        a = 6'($urandom);
        b = a ^ 6'h2a;
        idl = a ^ 6'h15;
        sa = 9'($urandom);
        n = 32'($urandom_range(6, 2));
        w16 = (cfg == 2);
        v0 = '0;
        v0.ctl = a;
        v0.rdy_pol = 1'b1;
        v1 = '0;
        v1.ctl = b;
        v1.rdy_sel = RDY_ALWAYS;
        v1.fifo_adv = 1'b1;
        v1.addr_inc = 1'b1;
        v1.data_oe = (cfg != 1);
        v1.last = 1'b1;
        wvec(8'h00, v0);
        wvec(8'h01, v1);
        wr(OFS_IDLE, {2'h0, idl});
        wr(OFS_ADRL, sa[7:0]);
        wr(OFS_ADRH, {7'h0, sa[8]});
        for (k = 0; k < 4; k++) wr(OFS_TC0 + 8'(k), n[8 * k +: 8]);
        c = '0;
        c[CTRL_W16] = w16;
        c[CTRL_FSEL +: 2] = 2'(cfg);
        c[CTRL_CSEL +: 2] = 2'(cfg);
        wr(OFS_CTRL, c);
        lk_en = (cfg == 2);
        hold_rdy <= 1'b1;
        seen_q = {};
        prev_ctl = WAVE_CONTROL_O;
        advs = adv_cnt;
        in_run = 1'b1;
        wr(OFS_CTRL, c | 8'h01);
        repeat (40) @(posedge CLK_I);
        chk("adv while not ready", 32'(advs), 32'(adv_cnt));
        stall <= 1'b1;
        hold_rdy <= 1'b0;
        repeat (40) @(posedge CLK_I);
        chk("adv while stalled", 32'(advs), 32'(adv_cnt));
        stall <= 1'b0;
        k = 0;
        d = 8'h00;
        while (d[STAT_DONE] !== 1'b1 && k < 500) begin
            rd(OFS_STAT, d);
            k++;
        end
        rdchk("status", OFS_STAT, 8'h02);
        in_run = 1'b0;
        lk_en = 1'b0;
        chk("adv count", 32'(advs) + n, 32'(adv_cnt));
        chk("address", 32'(sa + 9'(n)) & 32'h1ff, 32'(WAVE_ADDRESS_O));
        chk("fifo select", 32'(cfg), 32'(FIFO_SELECT_O));
        h = 16'h0001 + 16'(32'h103 * (adv_cnt - 1));
        if (!w16) h[15:8] = 8'h00;
        if (cfg != 1)
            chk("data out", 32'(h), 32'(DATA_O));
        chk("data oe idle", 32'h0, 32'(DATA_OE_O));
        for (k = 0; k < 4; k++)
            rdchk("count left", OFS_TC0 + 8'(k), 8'h00);
        chk("ctl edges", 2 * n + 1, 32'(seen_q.size()));
        for (k = 0; k < seen_q.size(); k++)
            chk("ctl level", (k == seen_q.size() - 1) ? idl : (k % 2 ? b : a),
                32'(seen_q[k]));
        wr(OFS_STAT, 8'h02);
        rdchk("done clear", OFS_STAT, 8'h00);
    endtask

    initial begin
        wbm_byte_t c;
        logic [23:0] r;
        void'($urandom(3709));
        repeat (4) @(posedge CLK_I);
        NRST_I <= 1'b1;
        rdchk("status reset", OFS_STAT, 8'h00);
        rdchk("unmapped", 8'h3c, 8'h00);
        chk("ctl reset", 32'h0, 32'(WAVE_CONTROL_O));
        for (int k = 0; k < 4; k++) begin
            c = 8'($urandom);
            wr(OFS_TC0 + 8'(k), c);
            rdchk("count byte", OFS_TC0 + 8'(k), c);
        end
        for (int k = 0; k < 3; k++) run(k);
        wr(OFS_CTRL, 8'h01);
        rdchk("go at zero", OFS_STAT, 8'h02);
        for (int k = 0; k < 1024; k++) bbuf[k] = 8'($urandom);
        wr(OFS_CTRL, 8'h00);
        wr(OFS_CRST, 8'($urandom));
        send(0, 600);
        rd24(OFS_E1B0, r);
        chk("code first", ecc(0, 256), r);
        rd24(OFS_E1B0 + 8'h03, r);
        chk("code second", ecc(256, 256), r);
        wr(OFS_CTRL, 8'h40);
        wr(OFS_CRST, 8'h00);
        send(600, 100);
        wr(OFS_CRST, 8'hff);
        send(100, 530);
        rd24(OFS_E1B0, r);
        chk("code single", ecc(100, 512), r);
        wr(OFS_CTRL, 8'h42);
        wr(OFS_CRST, 8'h00);
        send(0, 300);
        wr(OFS_CTRL, 8'h40);
        send(300, 512);
        rd24(OFS_E1B0, r);
        chk("code after wide", ecc(300, 512), r);
        close_out();
    end
endmodule
